// File: design/lpcc_ctrl.sv
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
// Summary of operation
// - Writing one to manual calibration bit starts a calibration cycle.
// - Auto-calibration disable bit set skips automatic calibration.
// - Current-limit bit selects the current-limiting termination mode.
// - Off-hook, overload enabled, loop level all ones: protect and flag overload.
// - Writing zero to overload enable leaves the protected state.
// - Off-hook, billing enabled, billing flag rises: 800 ohm, stop voltage tracking.
// - Otherwise termination-voltage pin follows the receive input.
// - Billing and receive-overload detection active once off-hook delay expires.
// - Receive overload flag sets on excessive input, cleared by writing zero.
// - Billing-tone flag sets on detected tone, cleared by writing zero.
// - All bits reset to zero; bit 7 reserved, reads zero.
module lpcc_ctrl
	import lpcc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        clk_en,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        off_hook,
	input  wire logic        offhook_delay_done,
	input  wire logic [4:0]  loop_current_level,
	input  wire logic        receive_below_ground,
	input  wire logic        billing_tone_seen,
	input  wire logic        receive_input,
	input  wire logic        cal_done,
	output logic             cal_start,
	output logic             auto_cal_disable,
	output logic             current_limit_select,
	output logic             dc_term_disable,
	output logic             hookswitch_reduce,
	output logic             overload_detected_flag,
	output logic             billing_protect_active,
	output logic             termination_voltage_pin
);

	typedef enum logic [1:0] {LPCC_IDLE = 2'b00, LPCC_CAL = 2'b01} lpcc_cal_e;

	logic [1:0] sync0_reg;
	logic [1:0] sync1_reg;
	logic [4:0] lvl0_reg;
	logic [4:0] lvl1_reg;
	logic [4:0] ext0_reg;
	logic [4:0] ext1_reg;
	logic [7:0] ctrl_reg;
	logic       wr_pend_reg;
	logic       rd_pend_reg;
	logic [31:0] addr_reg;
	logic       flag_prev_reg;
	logic       ovl_prot_reg;
	logic       bt_prot_reg;
	logic       ovl_seen_reg;
	logic       vtrack_reg;
	lpcc_cal_e  cal_reg;
	logic       cal_pulse_reg;
	logic [31:0] rdata_reg;

	logic s_off_hook;
	logic s_delay_done;
	logic s_rx_low;
	logic s_bt_seen;
	logic s_rx_in;
	logic s_cal_done;
	logic detect_en;
	logic wr_ctrl;
	logic addr_ok;
	logic take;

	assign s_off_hook   = sync1_reg[0];
	assign s_delay_done = sync1_reg[1];
	assign s_rx_low     = ext1_reg[0];
	assign s_bt_seen    = ext1_reg[1];
	assign s_rx_in      = ext1_reg[2];
	assign s_cal_done   = ext1_reg[3];

	// Pins cross two flip-flops before use
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync0_reg <= 2'b00;
			sync1_reg <= 2'b00;
			lvl0_reg  <= 5'h00;
			lvl1_reg  <= 5'h00;
			ext0_reg  <= 5'h00;
			ext1_reg  <= 5'h00;
		end else if (clk_en) begin
			sync0_reg <= {offhook_delay_done, off_hook};
			sync1_reg <= sync0_reg;
			lvl0_reg  <= loop_current_level;
			lvl1_reg  <= lvl0_reg;
			ext0_reg  <= {1'b0, cal_done, receive_input, billing_tone_seen,
				receive_below_ground};
			ext1_reg  <= ext0_reg;
		end
	end

	// Bus slave: zero wait states, unmapped reads return zero, writes ignored
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign take      = hsel && hready && (htrans == LPCC_HTRANS_NONSEQ)
		&& (hsize == LPCC_HSIZE_WORD);
	assign addr_ok   = (addr_reg == LPCC_ADDR_CONTROL);
	assign wr_ctrl   = wr_pend_reg && addr_ok;
	assign hrdata    = rdata_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			addr_reg    <= 32'h0000_0000;
		end else if (clk_en) begin
			wr_pend_reg <= take && hwrite;
			rd_pend_reg <= take && !hwrite;
			addr_reg    <= take ? haddr : addr_reg;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= 32'h0000_0000;
		end else if (clk_en && take && !hwrite) begin
			if (haddr == LPCC_ADDR_CONTROL) begin
				rdata_reg <= {24'h00_0000, ctrl_reg};
			end else if (haddr == LPCC_ADDR_STATUS) begin
				rdata_reg <= {28'h000_0000, bt_prot_reg, ovl_prot_reg, cal_reg == LPCC_CAL,
					ovl_seen_reg};
			end else begin
				rdata_reg <= 32'h0000_0000;
			end
		end
	end

	// detection gated by off-hook and by off-hook delay done
	assign detect_en = s_off_hook && s_delay_done;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= LPCC_CONTROL_RESET;
		end else if (clk_en) begin
			if (wr_ctrl) begin
				ctrl_reg[7:2] <= {1'b0, hwdata[6:2]};
			end else if (cal_reg == LPCC_CAL && s_cal_done) begin
				ctrl_reg[LPCC_BIT_CAL_START] <= 1'b0;
			end
			// receive overload sticky, set beats clear
			if (detect_en && s_rx_low) begin
				ctrl_reg[LPCC_BIT_RX_OVL] <= 1'b1;
			end else if (wr_ctrl && !hwdata[LPCC_BIT_RX_OVL]) begin
				ctrl_reg[LPCC_BIT_RX_OVL] <= 1'b0;
			end
			// billing flag sticky, set beats clear
			if (detect_en && s_bt_seen) begin
				ctrl_reg[LPCC_BIT_BILL_FLAG] <= 1'b1;
			end else if (wr_ctrl && !hwdata[LPCC_BIT_BILL_FLAG]) begin
				ctrl_reg[LPCC_BIT_BILL_FLAG] <= 1'b0;
			end
		end
	end

	// one-cycle start on a written one
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cal_reg       <= LPCC_IDLE;
			cal_pulse_reg <= 1'b0;
		end else if (clk_en) begin
			cal_pulse_reg <= 1'b0;
			unique case (cal_reg)
				LPCC_IDLE: begin
					if (wr_ctrl && hwdata[LPCC_BIT_CAL_START]) begin
						cal_reg       <= LPCC_CAL;
						cal_pulse_reg <= 1'b1;
					end
				end
				LPCC_CAL: begin
					if (s_cal_done) begin
						cal_reg <= LPCC_IDLE;
					end
				end
			endcase
		end
	end

	assign cal_start = cal_pulse_reg;
	assign auto_cal_disable = ctrl_reg[LPCC_BIT_CAL_OFF];
	assign current_limit_select = ctrl_reg[LPCC_BIT_CUR_LIMIT];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ovl_prot_reg <= 1'b0;
			ovl_seen_reg <= 1'b0;
		end else if (clk_en) begin
			if (!ctrl_reg[LPCC_BIT_OVL_EN]) begin
				ovl_prot_reg <= 1'b0;
			end else if (s_off_hook && lvl1_reg == LPCC_LOOP_FULL) begin
				ovl_prot_reg <= 1'b1;
			end
			if (s_off_hook && ctrl_reg[LPCC_BIT_OVL_EN] && lvl1_reg == LPCC_LOOP_FULL) begin
				ovl_seen_reg <= 1'b1;
			end else if (!ctrl_reg[LPCC_BIT_OVL_EN]) begin
				ovl_seen_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_prev_reg <= 1'b0;
			bt_prot_reg   <= 1'b0;
		end else if (clk_en) begin
			flag_prev_reg <= ctrl_reg[LPCC_BIT_BILL_FLAG];
			if (!s_off_hook || !ctrl_reg[LPCC_BIT_BILL_EN] || !ctrl_reg[LPCC_BIT_BILL_FLAG]) begin
				bt_prot_reg <= 1'b0;
			end else if (ctrl_reg[LPCC_BIT_BILL_FLAG] && !flag_prev_reg) begin
				bt_prot_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			vtrack_reg <= 1'b0;
		end else if (clk_en && !bt_prot_reg) begin
			vtrack_reg <= s_rx_in;
		end
	end

	assign dc_term_disable         = ovl_prot_reg || bt_prot_reg;
	assign hookswitch_reduce       = ovl_prot_reg;
	assign overload_detected_flag  = ovl_seen_reg;
	assign billing_protect_active  = bt_prot_reg;
	assign termination_voltage_pin = vtrack_reg;

	property p_rx_ovl_set;
		@(posedge clk) disable iff (!rst_n)
		(clk_en && $rose(ctrl_reg[LPCC_BIT_RX_OVL])) |-> $past(detect_en && s_rx_low);
	endproperty
	a_rx_ovl_set: assert property (p_rx_ovl_set) else $error("overload flag set without cause");

	property p_bill_flag_set;
		@(posedge clk) disable iff (!rst_n)
		(clk_en && $rose(ctrl_reg[LPCC_BIT_BILL_FLAG])) |-> $past(detect_en && s_bt_seen);
	endproperty
	a_bill_flag_set: assert property (p_bill_flag_set) else $error("tone flag set without cause");

	// Clear only lands when no detection competes in the same cycle
	property p_bill_flag_clear;
		@(posedge clk) disable iff (!rst_n)
		(clk_en && wr_ctrl && !hwdata[LPCC_BIT_BILL_FLAG] && !(detect_en && s_bt_seen))
			|=> !ctrl_reg[LPCC_BIT_BILL_FLAG];
	endproperty
	a_bill_flag_clear: assert property (p_bill_flag_clear) else $error("tone flag not cleared");

	property p_no_sw_set;
		@(posedge clk) disable iff (!rst_n)
		(clk_en && wr_ctrl && !(detect_en && s_rx_low) && !ctrl_reg[LPCC_BIT_RX_OVL])
			|=> !ctrl_reg[LPCC_BIT_RX_OVL];
	endproperty
	a_no_sw_set: assert property (p_no_sw_set) else $error("overload flag set by write");

	property p_cal;
		@(posedge clk) disable iff (!rst_n)
		(clk_en && wr_ctrl && hwdata[LPCC_BIT_CAL_START] && cal_reg == LPCC_IDLE) |=> cal_start;
	endproperty
	a_cal: assert property (p_cal) else $error("calibration not started");

	property p_auto_cal;
		@(posedge clk) disable iff (!rst_n)
		(clk_en && wr_ctrl) |=> (auto_cal_disable == $past(hwdata[LPCC_BIT_CAL_OFF]));
	endproperty
	a_auto_cal: assert property (p_auto_cal) else $error("auto calibration bit wrong");

	property p_cur_limit;
		@(posedge clk) disable iff (!rst_n)
		(clk_en && wr_ctrl) |=> (current_limit_select == $past(hwdata[LPCC_BIT_CUR_LIMIT]));
	endproperty
	a_cur_limit: assert property (p_cur_limit) else $error("current limit bit wrong");

	property p_ovl;
		@(posedge clk) disable iff (!rst_n)
		(clk_en && s_off_hook && ctrl_reg[LPCC_BIT_OVL_EN] && lvl1_reg == LPCC_LOOP_FULL)
			|=> (dc_term_disable && hookswitch_reduce && overload_detected_flag);
	endproperty
	a_ovl: assert property (p_ovl) else $error("overload protection missing");

	property p_ovl_clear;
		@(posedge clk) disable iff (!rst_n)
		(clk_en && !ctrl_reg[LPCC_BIT_OVL_EN]) |=> !hookswitch_reduce;
	endproperty
	a_ovl_clear: assert property (p_ovl_clear) else $error("overload state not left");

	property p_vtrack;
		@(posedge clk) disable iff (!rst_n)
		(clk_en && !bt_prot_reg) |=> (termination_voltage_pin == $past(s_rx_in));
	endproperty
	a_vtrack: assert property (p_vtrack) else $error("voltage pin not tracking");

	property p_bt_entry;
		@(posedge clk) disable iff (!rst_n)
		(clk_en && s_off_hook && ctrl_reg[LPCC_BIT_BILL_EN] && ctrl_reg[LPCC_BIT_BILL_FLAG]
			&& !flag_prev_reg) |=> billing_protect_active;
	endproperty
	a_bt_entry: assert property (p_bt_entry) else $error("billing protect not entered");

	// Protection may end next cycle, so only dc_term_disable this cycle and a stable pin the next are demanded
	sequence s_bt_term;
		dc_term_disable;
	endsequence

	sequence s_bt_frozen;
		$stable(termination_voltage_pin);
	endsequence

	property p_bt_hold;
		@(posedge clk) disable iff (!rst_n)
		(clk_en && bt_prot_reg) |-> s_bt_term ##1 s_bt_frozen;
	endproperty
	a_bt_hold: assert property (p_bt_hold) else $error("billing protect not held");

	property p_rsv;
		@(posedge clk) disable iff (!rst_n)
		1'b1 |-> !ctrl_reg[7];
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bit set");

endmodule

// File: design/lpcc_pkg.sv
package lpcc_pkg;
	// Offset 0x11 is not a multiple of four: kept as index, byte address is four times it
	localparam logic [7:0]  LPCC_IDX_CONTROL   = 8'h11;
	localparam logic [31:0] LPCC_ADDR_CONTROL  = {22'h00_0000, LPCC_IDX_CONTROL, 2'b00};
	localparam logic [31:0] LPCC_ADDR_STATUS   = 32'h0000_0060;
	localparam logic [7:0]  LPCC_CONTROL_RESET = 8'h00;
	localparam logic [7:0]  LPCC_STATUS_RESET  = 8'h00;
	localparam int LPCC_BIT_CAL_START  = 6;
	localparam int LPCC_BIT_CAL_OFF    = 5;
	localparam int LPCC_BIT_CUR_LIMIT  = 4;
	localparam int LPCC_BIT_OVL_EN     = 3;
	localparam int LPCC_BIT_BILL_EN    = 2;
	localparam int LPCC_BIT_RX_OVL     = 1;
	localparam int LPCC_BIT_BILL_FLAG  = 0;
	localparam logic [4:0]  LPCC_LOOP_FULL     = 5'h1F;
	localparam logic [1:0]  LPCC_HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0]  LPCC_HSIZE_WORD    = 3'h2;
endpackage

// File: verif/testbench.sv
`timescale 1ns/1ns
module testbench;
	import lpcc_pkg::*;
	logic        clk, rst_n, clk_en, hsel, hwrite, cal_done;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [4:0]  loop_current_level;
	logic        off_hook, offhook_delay_done, receive_below_ground, billing_tone_seen;
	logic        receive_input, hreadyout, hresp, cal_start, auto_cal_disable;
	logic        current_limit_select, dc_term_disable, hookswitch_reduce;
	logic        overload_detected_flag, billing_protect_active, termination_voltage_pin, v;
	wire logic   hready;
	int          num_errors, n_checks, n_cal_pulses;

	assign hready = hreadyout;

	lpcc_ctrl i_dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .off_hook(off_hook),
		.offhook_delay_done(offhook_delay_done), .loop_current_level(loop_current_level),
		.receive_below_ground(receive_below_ground), .billing_tone_seen(billing_tone_seen),
		.receive_input(receive_input), .cal_done(cal_done), .cal_start(cal_start),
		.auto_cal_disable(auto_cal_disable), .current_limit_select(current_limit_select),
		.dc_term_disable(dc_term_disable), .hookswitch_reduce(hookswitch_reduce),
		.overload_detected_flag(overload_detected_flag),
		.billing_protect_active(billing_protect_active),
		.termination_voltage_pin(termination_voltage_pin));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Pulse count, so a level stuck high shows up as more than one
	always @(posedge clk) begin
		if (cal_start === 1'b1) n_cal_pulses++;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
		end
	endtask

	// Single word transfer; address phase held until hready, data phase likewise
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
		@(posedge clk);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= LPCC_HTRANS_NONSEQ;
		hwrite <= w;
		hsize  <= LPCC_HSIZE_WORD;
		do @(posedge clk); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
		ahb(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask

	task automatic test_reset_map();
		rd_chk(LPCC_ADDR_CONTROL, 32'h0000_0000);
		chk({24'h00_0000, auto_cal_disable, current_limit_select, dc_term_disable,
			hookswitch_reduce, overload_detected_flag, billing_protect_active, 2'b00},
			32'h0000_0000);
		chk({hreadyout, hresp}, 2'b10);
		ahb(1'b1, 32'h0000_0080, 32'h0000_00FF);
		rd_chk(32'h0000_0080, 32'h0000_0000);
		rd_chk(LPCC_ADDR_CONTROL, 32'h0000_0000);
		$display("test reset_map done");
	endtask

	task automatic test_cal_bits();
		ahb(1'b1, LPCC_ADDR_CONTROL, 32'h0000_00FF);
		repeat (4) @(posedge clk);
		// Flags and reserved bit stay clear after writing ones
		rd_chk(LPCC_ADDR_CONTROL, 32'h0000_007C);
		chk(n_cal_pulses, 1);
		chk(auto_cal_disable, 1'b1);
		chk(current_limit_select, 1'b1);
		@(posedge clk) cal_done <= 1'b1;
		repeat (5) @(posedge clk);
		rd_chk(LPCC_ADDR_CONTROL, 32'h0000_003C);
		cal_done <= 1'b0;
		ahb(1'b1, LPCC_ADDR_CONTROL, 32'h0000_0000);
		repeat (2) @(posedge clk);
		chk({auto_cal_disable, current_limit_select}, 2'b00);
		chk(n_cal_pulses, 1);
		$display("test cal_bits done");
	endtask

	task automatic test_overload();
		@(posedge clk) off_hook <= 1'b1;
		offhook_delay_done <= 1'b1;
		repeat (20) @(posedge clk);
		loop_current_level <= LPCC_LOOP_FULL;
		ahb(1'b1, LPCC_ADDR_CONTROL, 32'h0000_0008);
		repeat (6) @(posedge clk);
		chk({dc_term_disable, hookswitch_reduce, overload_detected_flag}, 3'b111);
		ahb(1'b0, LPCC_ADDR_STATUS, 32'h0000_0000);
		chk(rd & 32'h0000_0001, 32'h0000_0001);
		ahb(1'b1, LPCC_ADDR_CONTROL, 32'h0000_0000);
		repeat (4) @(posedge clk);
		chk({dc_term_disable, hookswitch_reduce, overload_detected_flag}, 3'b000);
		loop_current_level <= 5'h00;
		$display("test overload done");
	endtask

	task automatic test_billing();
		@(posedge clk) receive_input <= 1'b1;
		repeat (6) @(posedge clk);
		chk(termination_voltage_pin, 1'b1);
		ahb(1'b1, LPCC_ADDR_CONTROL, 32'h0000_0004);
		billing_tone_seen <= 1'b1;
		repeat (6) @(posedge clk);
		rd_chk(LPCC_ADDR_CONTROL, 32'h0000_0005);
		chk(billing_protect_active, 1'b1);
		v = termination_voltage_pin;
		receive_input <= 1'b0;
		repeat (6) @(posedge clk);
		chk(termination_voltage_pin, v);
		billing_tone_seen <= 1'b0;
		repeat (4) @(posedge clk);
		rd_chk(LPCC_ADDR_CONTROL, 32'h0000_0005);
		ahb(1'b1, LPCC_ADDR_CONTROL, 32'h0000_0004);
		rd_chk(LPCC_ADDR_CONTROL, 32'h0000_0004);
		repeat (6) @(posedge clk);
		chk({billing_protect_active, termination_voltage_pin}, 2'b00);
		ahb(1'b1, LPCC_ADDR_CONTROL, 32'h0000_0000);
		$display("test billing done");
	endtask

	task automatic test_rx_ovl();
		@(posedge clk) offhook_delay_done <= 1'b0;
		receive_below_ground <= 1'b1;
		billing_tone_seen <= 1'b1;
		repeat (6) @(posedge clk);
		rd_chk(LPCC_ADDR_CONTROL, 32'h0000_0000);
		offhook_delay_done <= 1'b1;
		repeat (6) @(posedge clk);
		receive_below_ground <= 1'b0;
		billing_tone_seen <= 1'b0;
		repeat (4) @(posedge clk);
		// Protection enable left at zero: detection still runs
		rd_chk(LPCC_ADDR_CONTROL, 32'h0000_0003);
		ahb(1'b1, LPCC_ADDR_CONTROL, 32'h0000_0003);
		rd_chk(LPCC_ADDR_CONTROL, 32'h0000_0003);
		ahb(1'b1, LPCC_ADDR_CONTROL, 32'h0000_0000);
		rd_chk(LPCC_ADDR_CONTROL, 32'h0000_0000);
		off_hook <= 1'b0;
		$display("test rx_ovl done");
	endtask

	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		{rst_n, hsel, hwrite, cal_done, off_hook, offhook_delay_done} = 6'b00_0000;
		{receive_below_ground, billing_tone_seen, receive_input} = 3'b000;
		clk_en = 1'b1;
		haddr = 32'h0000_0000;
		hwdata = 32'h0000_0000;
		htrans = 2'h0;
		hsize = LPCC_HSIZE_WORD;
		loop_current_level = 5'h00;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		test_reset_map();
		test_cal_bits();
		test_overload();
		test_billing();
		test_rx_ovl();
		give_verdict();
	end

	// Whole run is well under a thousand cycles
	initial begin
		#50000;
		num_errors++;
		give_verdict();
	end
endmodule
